// >>> hw/camb_pkg.sv
/*
  Package for the CAN acceptance mask bank: register offsets, field layout,
  widths and the match helper shared by the bank and its match unit.
  Assumes a 16-bit register port with one word per offset.
*/
package camb_pkg;

  // ------------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------------
  localparam int unsigned NUM_SETS  = 3;
  localparam int unsigned DATA_W    = 16;
  localparam int unsigned ADDR_W    = 4;
  localparam int unsigned SID_W     = 11;
  localparam int unsigned EID_W     = 18;
  localparam int unsigned SET_W     = 2;

  // ------------------------------------------------------------------
  // Register offsets (word index)
  // ------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_STD_MASK0 = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_EXT_MASK0 = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_SET_STEP  = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_FILTER_ID = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_FILTER_EX = 4'h9;
  localparam logic [ADDR_W-1:0] OFS_CTRL      = 4'hA;
  localparam logic [ADDR_W-1:0] OFS_STATUS    = 4'hB;

  // ------------------------------------------------------------------
  // Field layout of the standard mask register
  // ------------------------------------------------------------------
  localparam int unsigned SID_LSB       = 5;
  localparam int unsigned MODE_BIT      = 3;
  localparam int unsigned EXT_HI_LSB    = 0;
  localparam logic [DATA_W-1:0] STD_WMASK = 16'hFFEB;

  // Filter extended register fields
  localparam int unsigned FILT_FILTER_EXTENDED_SELECT_BIT = 0;
  localparam int unsigned FILT_SET_LSB   = 1;

  // Reset values of control state
  localparam logic [DATA_W-1:0] RST_WORD = 16'h0000;

  // Masked compare: masked XOR all zero
  function automatic logic masked_eq(input logic [EID_W-1:0] a,
                                     input logic [EID_W-1:0] b,
                                     input logic [EID_W-1:0] m);
    masked_eq = ((a ^ b) & m) == '0;
  endfunction : masked_eq

endpackage : camb_pkg

// >>> hw/camb_match_if.sv
/*
  Interface carrying one mask set, filter and frame to the match unit.
  Assumes the bank drives everything but the result.
*/
interface camb_match_if;
  import camb_pkg::*;
  logic [SID_W-1:0] mask_sid;
  logic [EID_W-1:0] mask_eid;
  logic             mode;
  logic [SID_W-1:0] filt_sid;
  logic [EID_W-1:0] filt_eid;
  logic             filt_ext;
  logic [SID_W-1:0] frm_sid;
  logic [EID_W-1:0] frm_eid;
  logic             frm_ext;
  logic             hit;
  modport bank  (output mask_sid, mask_eid, mode, filt_sid, filt_eid, filt_ext,
                 frm_sid, frm_eid, frm_ext, input hit);
  modport match (input mask_sid, mask_eid, mode, filt_sid, filt_eid, filt_ext,
                 frm_sid, frm_eid, frm_ext, output hit);
endinterface : camb_match_if

// >>> hw/camb_match.sv
/*
  Combinational acceptance test of one frame against one filter and mask set.
  Assumes stable inputs from the bank in the same cycle.
*/
module camb_match (
  // Match port
  camb_match_if.match m
);
  import camb_pkg::*;

  logic sid_ok;
  logic eid_ok;
  logic type_ok;

  always_comb begin
    sid_ok  = masked_eq({7'h00, m.frm_sid}, {7'h00, m.filt_sid},
                        {7'h00, m.mask_sid});
    eid_ok  = masked_eq(m.frm_eid, m.filt_eid, m.mask_eid);
    type_ok = !m.mode || (m.frm_ext == m.filt_ext);
    m.hit   = type_ok && sid_ok && (!m.frm_ext || eid_ok);
  end

endmodule : camb_match

// >>> hw/camb_mask_bank.sv
/*
  Acceptance mask bank: three mask sets reachable over a plain register port,
  plus two filter words and a frame check port that reports the match result.
  Assumes strobes are one cycle long and never both high together.
*/

// Notes on behaviour
// - Three independent mask sets, 0 to 2, each standard plus extended register.
// - Mask bit one: identifier bit must equal the filter bit.
// - Mask bit zero: identifier bit is ignored in the compare.
// - Mode bit one: frame type must agree with the filter extended select.
// - Mode bit zero: any type; extended frames also compare extended bits.
// - Standard register: mask bits 15..5, extended high in 1..0; extended register 15..0.
module camb_mask_bank (
  // Clock and reset
  input  wire  logic                           MCLK,
  input  wire  logic                           SRST,
  // Register port
  input  wire  logic [camb_pkg::ADDR_W-1:0]    ADDR,
  input  wire  logic [camb_pkg::DATA_W-1:0]    WDATA,
  input  wire  logic                           WR,
  input  wire  logic                           RD,
  output logic       [camb_pkg::DATA_W-1:0]    RDATA,
  // Received frame
  input  wire  logic                           FRM_VALID,
  input  wire  logic [camb_pkg::SID_W-1:0]     FRM_SID,
  input  wire  logic [camb_pkg::EID_W-1:0]     FRM_EID,
  input  wire  logic                           FRM_EXT,
  // Match result
  output logic                                 MATCH_VALID,
  output logic                                 MATCH_HIT
);
  import camb_pkg::*;

  // ------------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------------
  logic [DATA_W-1:0] std_q [NUM_SETS];
  logic [DATA_W-1:0] std_d [NUM_SETS];
  logic [DATA_W-1:0] ext_q [NUM_SETS];
  logic [DATA_W-1:0] ext_d [NUM_SETS];
  logic [DATA_W-1:0] fid_q, fid_d;
  logic [DATA_W-1:0] fex_q, fex_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic              mv_q, mv_d;
  logic              mh_q, mh_d;
  logic              last_hit_q, last_hit_d;
  logic [SET_W-1:0]  sel;
  logic              hit;

  camb_match_if mi ();

  // Address decode of a mask set register
  function automatic logic is_reg(input logic [ADDR_W-1:0] a,
                                  input logic [ADDR_W-1:0] base, input int unsigned n);
    is_reg = (a == ADDR_W'(base + ADDR_W'(n) * OFS_SET_STEP));
  endfunction : is_reg

  // ------------------------------------------------------------------
  // Mask set write path
  // ------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_SETS; g++) begin : g_set
      always_comb begin
        std_d[g] = std_q[g];
        ext_d[g] = ext_q[g];
        if (WR && is_reg(ADDR, OFS_STD_MASK0, g)) begin
          std_d[g] = WDATA & STD_WMASK;
        end
        if (WR && is_reg(ADDR, OFS_EXT_MASK0, g)) begin
          ext_d[g] = WDATA;
        end
      end
      // Mask contents are left undefined by reset
      always_ff @(posedge MCLK) begin
        std_q[g] <= std_d[g];
        ext_q[g] <= ext_d[g];
      end
    end
  endgenerate

  // ------------------------------------------------------------------
  // Filter, read port and result
  // ------------------------------------------------------------------
  always_comb begin
    fid_d      = fid_q;
    fex_d      = fex_q;
    rdata_d    = RST_WORD;
    last_hit_d = last_hit_q;
    if (WR && ADDR == OFS_FILTER_ID) begin
      fid_d = WDATA;
    end
    if (WR && ADDR == OFS_FILTER_EX) begin
      fex_d = WDATA;
    end
    if (FRM_VALID) begin
      last_hit_d = hit;
    end
    if (RD) begin
      for (int i = 0; i < NUM_SETS; i++) begin
        if (is_reg(ADDR, OFS_STD_MASK0, i)) rdata_d = std_q[i] & STD_WMASK;
        if (is_reg(ADDR, OFS_EXT_MASK0, i)) rdata_d = ext_q[i];
      end
      if (ADDR == OFS_FILTER_ID) rdata_d = fid_q;
      if (ADDR == OFS_FILTER_EX) rdata_d = fex_q;
      if (ADDR == OFS_STATUS)    rdata_d = {15'h0000, last_hit_q};
    end
    mv_d = FRM_VALID;
    mh_d = FRM_VALID && hit;
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      fid_q      <= RST_WORD;
      fex_q      <= RST_WORD;
      rdata_q    <= RST_WORD;
      mv_q       <= 1'b0;
      mh_q       <= 1'b0;
      last_hit_q <= 1'b0;
    end else begin
      fid_q      <= fid_d;
      fex_q      <= fex_d;
      rdata_q    <= rdata_d;
      mv_q       <= mv_d;
      mh_q       <= mh_d;
      last_hit_q <= last_hit_d;
    end
  end

  // ------------------------------------------------------------------
  // Selected set onto the match unit
  // ------------------------------------------------------------------
  always_comb begin
    sel = fex_q[FILT_SET_LSB +: SET_W];
    if (sel > SET_W'(NUM_SETS - 1)) sel = '0;
    mi.mask_sid = std_q[sel][SID_LSB +: SID_W];
    mi.mask_eid = {std_q[sel][EXT_HI_LSB +: 2], ext_q[sel]};
    mi.mode     = std_q[sel][MODE_BIT];
    mi.filt_sid = fid_q[SID_LSB +: SID_W];
    mi.filt_eid = {fid_q[EXT_HI_LSB +: 2], fex_q};
    mi.filt_ext = fex_q[FILT_FILTER_EXTENDED_SELECT_BIT] ^ 1'b0;
    mi.frm_sid  = FRM_SID;
    mi.frm_eid  = FRM_EID;
    mi.frm_ext  = FRM_EXT;
  end

  assign hit = mi.hit;

  camb_match u_match (
    .m (mi.match)
  );

  assign RDATA       = rdata_q;
  assign MATCH_VALID = mv_q;
  assign MATCH_HIT   = mh_q;

  // ------------------------------------------------------------------
  // Register access sequences
  // ------------------------------------------------------------------
  sequence s_std0_write;
    WR && ADDR == OFS_STD_MASK0;
  endsequence : s_std0_write
  sequence s_std0_read;
    RD && ADDR == OFS_STD_MASK0;
  endsequence : s_std0_read
  sequence s_ext0_write;
    WR && ADDR == OFS_EXT_MASK0;
  endsequence : s_ext0_write
  sequence s_ext0_read;
    RD && ADDR == OFS_EXT_MASK0;
  endsequence : s_ext0_read

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  a_unimpl_zero: assert property (@(posedge MCLK) disable iff (SRST)
    RD && ADDR == OFS_STD_MASK0 |=> RDATA[4] == 1'b0 && RDATA[2] == 1'b0)
    else $error("unimplemented bits read nonzero");
  a_ext_roundtrip: assert property (@(posedge MCLK) disable iff (SRST)
    s_ext0_write ##1 s_ext0_read |=> RDATA == $past(WDATA, 2))
    else $error("extended mask readback wrong");
  a_std_roundtrip: assert property (@(posedge MCLK) disable iff (SRST)
    s_std0_write ##1 s_std0_read |=> RDATA == ($past(WDATA, 2) & STD_WMASK))
    else $error("standard mask readback wrong");
  a_unimpl_write: assert property (@(posedge MCLK) disable iff (SRST)
    s_std0_write |=> std_q[0][4] == 1'b0 && std_q[0][2] == 1'b0)
    else $error("unimplemented bits stored");
  a_result_follows: assert property (@(posedge MCLK) disable iff (SRST)
    MATCH_HIT |-> $past(FRM_VALID))
    else $error("hit without frame");
  a_type_gate: assert property (@(posedge MCLK) disable iff (SRST)
    FRM_VALID && mi.mode && FRM_EXT != mi.filt_ext |=> !MATCH_HIT)
    else $error("type mismatch accepted");
  a_zero_mask: assert property (@(posedge MCLK) disable iff (SRST)
    FRM_VALID && !mi.mode && !FRM_EXT && mi.mask_sid == '0 |=> MATCH_HIT)
    else $error("empty mask rejected frame");
  a_full_mask: assert property (@(posedge MCLK) disable iff (SRST)
    FRM_VALID && mi.mask_sid[0] && FRM_SID[0] != mi.filt_sid[0] |=> !MATCH_HIT)
    else $error("masked bit mismatch accepted");
  a_std_ignores_eid: assert property (@(posedge MCLK) disable iff (SRST)
    FRM_VALID && !mi.mode && !FRM_EXT && mi.mask_sid == '0 && mi.mask_eid != '0
    |=> MATCH_HIT)
    else $error("standard frame used extended bits");
  a_set_route: assert property (@(posedge MCLK) disable iff (SRST)
    fex_q[FILT_SET_LSB +: SET_W] == SET_W'(1)
    |-> mi.mask_eid[DATA_W-1:0] == ext_q[1] && mi.mode == std_q[1][MODE_BIT])
    else $error("mask set 1 not routed to the match unit");
  a_valid_pulse: assert property (@(posedge MCLK) disable iff (SRST)
    FRM_VALID |=> MATCH_VALID)
    else $error("frame not answered");
  a_hit_pulse: assert property (@(posedge MCLK) disable iff (SRST)
    MATCH_HIT |-> MATCH_VALID)
    else $error("hit outside a result");
  a_eid_mismatch: assert property (@(posedge MCLK) disable iff (SRST)
    FRM_VALID && FRM_EXT && mi.mask_eid[0] && FRM_EID[0] != mi.filt_eid[0] |=> !MATCH_HIT)
    else $error("masked extended bit mismatch accepted");
  a_ext_hi_field: assert property (@(posedge MCLK) disable iff (SRST)
    FRM_VALID && FRM_EXT && mi.mask_eid[EID_W-1] && FRM_EID[EID_W-1] != mi.filt_eid[EID_W-1]
    |=> !MATCH_HIT)
    else $error("extended high mask bit ignored");

endmodule : camb_mask_bank

// >>> tb/camb_frame_src.sv
/*
  Frame source model for the mask bank: presents received identifiers.
  Assumes the bank samples a frame at the rising edge where FRM_VALID is high.
*/
module camb_frame_src (
  // Clock
  input  wire logic                         MCLK,
  // Frame out
  output logic                              FRM_VALID,
  output logic      [camb_pkg::SID_W-1:0]   FRM_SID,
  output logic      [camb_pkg::EID_W-1:0]   FRM_EID,
  output logic                              FRM_EXT
);
  timeunit 1ns;
  timeprecision 1ps;
  import camb_pkg::*;

  initial begin
    FRM_VALID = 1'b0;
    FRM_SID   = '0;
    FRM_EID   = '0;
    FRM_EXT   = 1'b0;
  end

  // One frame for one cycle; idle lines then show the inverse
  task automatic send(input logic [SID_W-1:0] sid, input logic [EID_W-1:0] eid,
                      input logic ext);
    @(posedge MCLK);
    FRM_VALID <= 1'b1;
    FRM_SID   <= sid;
    FRM_EID   <= eid;
    FRM_EXT   <= ext;
    @(posedge MCLK);
    FRM_VALID <= 1'b0;
    FRM_SID   <= ~sid;
    FRM_EID   <= ~eid;
    FRM_EXT   <= ~ext;
  endtask : send
endmodule : camb_frame_src

// >>> tb/can_acceptance_mask_bank_bench.sv
/*
  Bench for the mask bank: register tasks, frame checks and verdict.
  Assumes the offsets of camb_pkg and the frame source model.
*/
module can_acceptance_mask_bank_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import camb_pkg::*;
  logic              MCLK, SRST, WR, RD, FRM_VALID, FRM_EXT, MATCH_VALID, MATCH_HIT;
  logic [ADDR_W-1:0] ADDR;
  logic [DATA_W-1:0] WDATA, RDATA;
  logic [SID_W-1:0]  FRM_SID;
  logic [EID_W-1:0]  FRM_EID;
  int                errors, num_checks;
  logic [DATA_W-1:0] sw [3] = '{16'hFFFF, 16'h0014, 16'h5555};
  logic [DATA_W-1:0] sr [3] = '{16'hFFEB, 16'h0000, 16'h5541};

  camb_mask_bank u_camb_mask_bank (.MCLK(MCLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .FRM_VALID(FRM_VALID), .FRM_SID(FRM_SID),
    .FRM_EID(FRM_EID), .FRM_EXT(FRM_EXT), .MATCH_VALID(MATCH_VALID), .MATCH_HIT(MATCH_HIT));
  camb_frame_src u_camb_frame_src (.MCLK(MCLK), .FRM_VALID(FRM_VALID), .FRM_SID(FRM_SID),
    .FRM_EID(FRM_EID), .FRM_EXT(FRM_EXT));

  task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] s);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk16

  task automatic chk1(input string nm, input logic e, input logic s);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s expected %b seen %b", nm, e, s);
    end
  endtask : chk1

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge MCLK);
    WR    <= 1'b1;
    ADDR  <= a;
    WDATA <= d;
    @(posedge MCLK);
    WR    <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge MCLK);
    RD   <= 1'b1;
    ADDR <= a;
    @(posedge MCLK);
    RD   <= 1'b0;
    #1;
    chk16("rdata", e, RDATA);
  endtask : rd_chk

  task automatic wr_rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                           input logic [DATA_W-1:0] e);
    @(posedge MCLK);
    WR    <= 1'b1;
    ADDR  <= a;
    WDATA <= d;
    @(posedge MCLK);
    WR    <= 1'b0;
    RD    <= 1'b1;
    @(posedge MCLK);
    RD    <= 1'b0;
    #1;
    chk16("rdata_b2b", e, RDATA);
  endtask : wr_rd_chk

  task automatic frm_chk(input logic [SID_W-1:0] sid, input logic [EID_W-1:0] eid,
                         input logic ext, input logic e);
    u_camb_frame_src.send(sid, eid, ext);
    #1;
    chk1("match_valid", 1'b1, MATCH_VALID);
    chk1("match_hit", e, MATCH_HIT);
    @(posedge MCLK);
    #1;
    chk1("match_valid", 1'b0, MATCH_VALID);
  endtask : frm_chk

  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results

  initial begin
    MCLK = 1'b0;
    forever #20 MCLK = ~MCLK;
  end

  initial begin
    repeat (5000) @(posedge MCLK);
    errors++;
    results();
  end

  initial begin
    SRST  = 1'b1;
    WR    = 1'b0;
    RD    = 1'b0;
    ADDR  = '0;
    WDATA = '0;
    repeat (4) @(posedge MCLK);
    SRST <= 1'b0;
    #1;
    chk1("match_valid", 1'b0, MATCH_VALID);
    chk16("rdata", 16'h0000, RDATA);
    $display("test reset done");
    // Register layout, unimplemented bits, set independence
    for (int n = 0; n < 3; n++) begin
      wr_reg(ADDR_W'(2 * n), sw[n]);
      wr_reg(ADDR_W'(2 * n + 1), 16'h1230 + DATA_W'(n));
    end
    for (int n = 0; n < 3; n++) begin
      rd_chk(ADDR_W'(2 * n), sr[n]);
      rd_chk(ADDR_W'(2 * n + 1), 16'h1230 + DATA_W'(n));
    end
    wr_reg(4'hC, 16'hFFFF);
    rd_chk(4'hC, 16'h0000);
    rd_chk(OFS_CTRL, 16'h0000);
    wr_rd_chk(OFS_STD_MASK0, 16'h0014, 16'h0000);
    wr_rd_chk(OFS_EXT_MASK0, 16'hA5A5, 16'hA5A5);
    $display("test registers done");
    // Set 0 masks every bit; filter SID 0x123, EID 0x2BEE8
    wr_reg(OFS_STD_MASK0, 16'hFFE3);
    wr_reg(OFS_EXT_MASK0, 16'hFFFF);
    wr_reg(OFS_FILTER_ID, 16'h2462);
    wr_reg(OFS_FILTER_EX, 16'hBEE8);
    frm_chk(11'h123, 18'h00000, 1'b0, 1'b1);
    rd_chk(OFS_STATUS, 16'h0001);
    frm_chk(11'h122, 18'h00000, 1'b0, 1'b0);
    rd_chk(OFS_STATUS, 16'h0000);
    frm_chk(11'h123, 18'h2BEE8, 1'b1, 1'b1);
    frm_chk(11'h123, 18'h2BEE9, 1'b1, 1'b0);
    frm_chk(11'h123, 18'h0BEE8, 1'b1, 1'b0);
    // Clear SID bit 0 and EID bit 0 of the mask
    wr_reg(OFS_STD_MASK0, 16'hFFC3);
    wr_reg(OFS_EXT_MASK0, 16'hFFFE);
    frm_chk(11'h122, 18'h00000, 1'b0, 1'b1);
    frm_chk(11'h122, 18'h2BEE9, 1'b1, 1'b1);
    $display("test compare done");
    // Frame type must agree with the filter select
    wr_reg(OFS_STD_MASK0, 16'hFFCB);
    frm_chk(11'h123, 18'h2BEE8, 1'b1, 1'b0);
    frm_chk(11'h123, 18'h00000, 1'b0, 1'b1);
    wr_reg(OFS_FILTER_EX, 16'hBEE9);
    frm_chk(11'h123, 18'h2BEE9, 1'b1, 1'b1);
    frm_chk(11'h123, 18'h00000, 1'b0, 1'b0);
    $display("test mode done");
    // Set 1 has an empty SID mask; selector 3 falls back to set 0
    wr_reg(OFS_FILTER_EX, 16'hBEEA);
    frm_chk(11'h7FF, 18'h00000, 1'b0, 1'b1);
    wr_reg(OFS_FILTER_EX, 16'hBEEE);
    frm_chk(11'h7FF, 18'h00000, 1'b0, 1'b0);
    $display("test sets done");
    results();
  end
endmodule : can_acceptance_mask_bank_bench
